// ---- fdr_ramp.sv ----
// fan duty ramp control: APB registers, mode sequencing and duty stepping
// Function
// - remote slope sets duty rise per degree
// - ramp config resets to 0x52
// - ramp enabled moves duty gradually in auto
// - ramp disabled loads auto target at once
// - speed mode always ramps, ignores enable
// - auto ramp step limited by step field
// - speed mode applies step field each adjustment
// - auto without ramp ignores step field
// - final update applies only remaining difference
// - auto update rate from rate field
// - manual duty mode ignores ramp config
// - speed mode adjusts while speed off target
// - auto holds duty within threshold hysteresis
// - speed mode paced by fast tach bit
// - speed mode stops within 0x000A tach
module fdr_ramp import fdr_pkg::*; #(
  parameter int unsigned UPDATE_BASE_CYC = FAST_UPDATE_CYC,
  parameter int unsigned RPM_FAST_PER    = RPM_FAST_CYC,
  parameter int unsigned RPM_SLOW_PER    = RPM_SLOW_CYC
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // temperature loop inputs
  input  wire logic [7:0]  remote_temp,
  input  wire logic [7:0]  low_temp,
  input  wire logic [7:0]  low_duty,
  input  wire logic [2:0]  remote_slope_field,
  // speed loop inputs
  input  wire logic [15:0] tach_reading,
  input  wire logic [15:0] tach_target,
  // pwm duty
  output logic      [7:0]  duty_cycle_value
);

  // register state
  logic [7:0]  duty_ramp_config_q;
  logic [7:0]  duty_ramp_config_d;
  logic [7:0]  ctrl_q;
  logic [7:0]  ctrl_d;
  logic [7:0]  sw_duty_q;
  logic [7:0]  sw_duty_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        cfg_written_q;
  logic        cfg_written_d;

  // loop state
  fdr_state_t  state_q;
  fdr_state_t  state_d;
  logic [7:0]  duty_q;
  logic [7:0]  duty_d;

  // decoded fields and helpers
  logic             ramp_enable_bit;
  logic [1:0]       max_step_field;
  logic [2:0]       update_rate_field;
  logic [1:0]       adjust_threshold_field;
  logic             fast_tach_rate_bit;
  logic [7:0]       step_amt;
  logic [7:0]       thr_amt;
  logic [7:0]       auto_target;
  logic [7:0]       gap;
  logic [15:0]      tach_gap;
  logic             in_band;
  logic             tach_slow;
  logic             tick;
  logic             restart;
  logic [TMR_W-1:0] period;
  logic [IDX_W-1:0] word_idx;
  logic             hit;
  logic             wr_en;

  assign ramp_enable_bit        = duty_ramp_config_q[RAMP_EN_BIT];
  assign max_step_field         = duty_ramp_config_q[STEP_HI:STEP_LO];
  assign update_rate_field      = duty_ramp_config_q[RATE_HI:RATE_LO];
  assign adjust_threshold_field = duty_ramp_config_q[THR_HI:THR_LO];
  assign fast_tach_rate_bit     = ctrl_q[FAST_TACH_BIT];
  assign step_amt               = step_size(max_step_field);
  assign thr_amt                = thresh_size(adjust_threshold_field);

  // ---------------- apb slave ----------------
  assign word_idx = paddr[11:2];
  assign hit      = (paddr[1:0] == 2'h0) &&
                    ((word_idx == IDX_RAMP_CFG) || (word_idx == IDX_CTRL) ||
                     (word_idx == IDX_SW_DUTY) || (word_idx == IDX_STATUS));
  assign wr_en    = psel && penable && pwrite && hit;
  // read data is captured in the setup cycle, so no wait states are needed
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !hit;
  assign prdata   = prdata_q;

  always_comb begin
    duty_ramp_config_d = duty_ramp_config_q;
    ctrl_d             = ctrl_q;
    sw_duty_d          = sw_duty_q;
    cfg_written_d      = cfg_written_q;
    prdata_d           = prdata_q;
    if (wr_en) begin
      case (word_idx)
        IDX_RAMP_CFG: begin
          duty_ramp_config_d = pwdata[7:0];
          cfg_written_d      = 1'b1;
        end
        IDX_CTRL:    ctrl_d    = pwdata[7:0];
        IDX_SW_DUTY: sw_duty_d = pwdata[7:0];
        default:     ctrl_d    = ctrl_q;
      endcase
    end
    if (psel && !penable && !pwrite) begin
      prdata_d = 32'h0000_0000;
      if (paddr[1:0] == 2'h0) begin
        case (word_idx)
          IDX_RAMP_CFG: prdata_d[7:0] = duty_ramp_config_q;
          IDX_CTRL:     prdata_d[7:0] = ctrl_q;
          IDX_SW_DUTY:  prdata_d[7:0] = sw_duty_q;
          IDX_STATUS: begin
            prdata_d[7:0]                           = duty_q;
            prdata_d[STAT_TGT_LO +: 8]              = auto_target;
            prdata_d[STAT_STATE_LO +: 2]            = state_q;
          end
          default: prdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_ramp_config_q <= RAMP_CFG_RST;
      ctrl_q             <= CTRL_RST;
      sw_duty_q          <= SW_DUTY_RST;
      cfg_written_q      <= 1'b0;
      prdata_q           <= 32'h0000_0000;
    end else begin
      duty_ramp_config_q <= duty_ramp_config_d;
      ctrl_q             <= ctrl_d;
      sw_duty_q          <= sw_duty_d;
      cfg_written_q      <= cfg_written_d;
      prdata_q           <= prdata_d;
    end
  end

  // ---------------- loops ----------------
  fdr_target u_target (
    .pclk               (pclk),
    .presetn            (presetn),
    .remote_temp        (remote_temp),
    .low_temp           (low_temp),
    .low_duty           (low_duty),
    .remote_slope_field (remote_slope_field),
    .target_duty        (auto_target)
  );

  always_comb begin
    case (state_q)
      ST_RPM:  period = fast_tach_rate_bit ? TMR_W'(RPM_FAST_PER) : TMR_W'(RPM_SLOW_PER);
      default: period = TMR_W'(UPDATE_BASE_CYC) << (RATE_FASTEST - update_rate_field);
    endcase
  end

  // a mode change starts a fresh update interval
  assign restart = (state_d != state_q);

  fdr_tick u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .period  (period),
    .restart (restart),
    .tick    (tick)
  );

  assign gap       = abs_diff(duty_q, auto_target);
  assign tach_gap  = (tach_reading > tach_target) ? (tach_reading - tach_target)
                                                  : (tach_target - tach_reading);
  assign in_band   = (tach_gap <= TACH_DEADBAND);
  // a larger tach count means a longer period, so the fan is too slow
  assign tach_slow = (tach_reading > tach_target);

  always_comb begin
    case (ctrl_q[MODE_HI:MODE_LO])
      MODE_MANUAL: state_d = ST_MANUAL;
      MODE_AUTO:   state_d = ST_AUTO;
      default:     state_d = ST_RPM;
    endcase
    duty_d = duty_q;
    case (state_q)
      ST_MANUAL: duty_d = sw_duty_q;
      ST_AUTO: begin
        if (gap > thr_amt) begin
          if (!ramp_enable_bit) begin
            duty_d = auto_target;
          end else if (tick) begin
            // gradual paced move; step bounded; exact remainder
            duty_d = ramp_toward(duty_q, auto_target, step_amt);
          end
        end
      end
      ST_RPM: begin
        // always ramps here; adjust when off target
        if (tick && !in_band) begin
          duty_d = step_sat(duty_q, step_amt, tach_slow);
        end
      end
      default: duty_d = duty_q;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_MANUAL;
      duty_q  <= SW_DUTY_RST;
    end else begin
      state_q <= state_d;
      duty_q  <= duty_d;
    end
  end

  assign duty_cycle_value = duty_q;

  // ---------------- checks ----------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_cfg_reset_val: assert property (
    !cfg_written_q |-> duty_ramp_config_q == RAMP_CFG_RST)
    else $error("ramp config left its reset value without a write");

  a_manual_follow: assert property (
    (state_q == ST_MANUAL) && (state_d == ST_MANUAL) ##1 (state_q == ST_MANUAL)
    |-> duty_q == $past(sw_duty_q))
    else $error("manual duty not following software value");

  a_auto_load_now: assert property (
    (state_q == ST_AUTO) && !ramp_enable_bit && (gap > thr_amt)
    |=> duty_q == $past(auto_target))
    else $error("ramp disabled but target not loaded at once");

  a_auto_step_bound: assert property (
    (state_q == ST_AUTO) && ramp_enable_bit
    |=> abs_diff(duty_q, $past(duty_q)) <= step_size($past(max_step_field)))
    else $error("auto duty moved more than one step");

  a_final_exact: assert property (
    (state_q == ST_AUTO) && ramp_enable_bit && tick && (gap > thr_amt) && (gap < step_amt)
    |=> duty_q == $past(auto_target))
    else $error("last ramp update did not land on target");

  a_hyst_hold: assert property (
    (state_q == ST_AUTO) && (gap <= thr_amt) |=> $stable(duty_q))
    else $error("duty changed inside the threshold band");

  a_rate_paced: assert property (
    (state_q == ST_AUTO) && ramp_enable_bit && !tick |=> $stable(duty_q))
    else $error("ramped duty changed without an update tick");

  a_rpm_deadband: assert property (
    (state_q == ST_RPM) && in_band |=> $stable(duty_q))
    else $error("speed loop adjusted inside the tach deadband");

  a_rpm_step_up: assert property (
    (state_q == ST_RPM) && tick && !in_band && tach_slow && (duty_q <= DUTY_MAX - step_amt)
    |=> duty_q == $past(duty_q) + $past(step_amt))
    else $error("speed loop step not applied upward");

  a_rpm_step_down: assert property (
    (state_q == ST_RPM) && tick && !in_band && !tach_slow && (duty_q >= step_amt)
    |=> duty_q == $past(duty_q) - $past(step_amt))
    else $error("speed loop step not applied downward");

  a_rpm_paced: assert property (
    (state_q == ST_RPM) && !tick |=> $stable(duty_q))
    else $error("speed loop changed duty without an update tick");

  a_rpm_clamp: assert property (
    (state_q == ST_RPM) && (duty_q == DUTY_MAX) && tach_slow |=> duty_q == DUTY_MAX)
    else $error("duty wrapped past full scale");

  c_auto_ramp:   cover property ((state_q == ST_AUTO) && ramp_enable_bit && tick && gap > thr_amt);
  c_auto_direct: cover property ((state_q == ST_AUTO) && !ramp_enable_bit && gap > thr_amt);
  c_rpm_adjust:  cover property ((state_q == ST_RPM) && tick && !in_band);
  c_manual:      cover property ((state_q == ST_MANUAL) ##1 (state_q == ST_AUTO));

endmodule

// ---- fdr_pkg.sv ----
// package: constants, register layout and helper functions for the fan duty ramp block
package fdr_pkg;

  // clock and update timing
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
  localparam int unsigned FAST_UPDATE_MS  = 125;
  localparam int unsigned FAST_UPDATE_CYC = CYC_PER_MS * FAST_UPDATE_MS;
  localparam int unsigned RPM_FAST_MS     = 250;
  localparam int unsigned RPM_FAST_CYC    = CYC_PER_MS * RPM_FAST_MS;
  localparam int unsigned RPM_SLOW_MS     = 1000;
  localparam int unsigned RPM_SLOW_CYC    = CYC_PER_MS * RPM_SLOW_MS;
  localparam int unsigned TMR_W           = 28;
  localparam logic [2:0]  RATE_FASTEST    = 3'h7;

  // register word indices; byte address is four times the index
  localparam int unsigned IDX_W        = 10;
  localparam logic [9:0]  IDX_RAMP_CFG = 10'h023;
  localparam logic [9:0]  IDX_CTRL     = 10'h030;
  localparam logic [9:0]  IDX_SW_DUTY  = 10'h031;
  localparam logic [9:0]  IDX_STATUS   = 10'h032;

  // reset values
  localparam logic [7:0] RAMP_CFG_RST = 8'h52;
  localparam logic [7:0] CTRL_RST     = 8'h00;
  localparam logic [7:0] SW_DUTY_RST  = 8'h00;

  // ramp config fields
  localparam int unsigned RAMP_EN_BIT = 7;
  localparam int unsigned STEP_HI     = 6;
  localparam int unsigned STEP_LO     = 5;
  localparam int unsigned RATE_HI     = 4;
  localparam int unsigned RATE_LO     = 2;
  localparam int unsigned THR_HI      = 1;
  localparam int unsigned THR_LO      = 0;

  // control fields
  localparam int unsigned MODE_HI       = 1;
  localparam int unsigned MODE_LO       = 0;
  localparam int unsigned FAST_TACH_BIT = 2;
  localparam logic [1:0]  MODE_MANUAL   = 2'h0;
  localparam logic [1:0]  MODE_AUTO     = 2'h1;

  // status fields
  localparam int unsigned STAT_TGT_LO   = 8;
  localparam int unsigned STAT_STATE_LO = 16;

  // loop constants
  localparam logic [15:0] TACH_DEADBAND  = 16'h000A;
  localparam logic [7:0]  DUTY_MAX       = 8'hFF;
  localparam logic [2:0]  SLOPE_MAX_CODE = 3'h4;
  localparam logic [5:0]  SLOPE_BASE     = 6'h20;

  typedef enum logic [1:0] {
    ST_MANUAL = 2'b00,
    ST_AUTO   = 2'b01,
    ST_RPM    = 2'b11
  } fdr_state_t;

  function automatic logic [7:0] step_size(input logic [1:0] code);
    step_size = 8'h01 << code;
  endfunction

  function automatic logic [7:0] thresh_size(input logic [1:0] code);
    thresh_size = {6'h00, code} + 8'h01;
  endfunction

  function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
    abs_diff = (a > b) ? (a - b) : (b - a);
  endfunction

  // move toward tgt by at most step, landing exactly on tgt when closer
  function automatic logic [7:0] ramp_toward(input logic [7:0] cur, input logic [7:0] tgt,
                                             input logic [7:0] step);
    if (abs_diff(cur, tgt) < step) ramp_toward = tgt;
    else if (tgt > cur) ramp_toward = cur + step;
    else ramp_toward = cur - step;
  endfunction

  // saturating move, never wraps past 0 or full scale
  function automatic logic [7:0] step_sat(input logic [7:0] cur, input logic [7:0] step,
                                          input logic up);
    if (up) step_sat = (DUTY_MAX - cur < step) ? DUTY_MAX : cur + step;
    else step_sat = (cur < step) ? 8'h00 : cur - step;
  endfunction

endpackage

// ---- fdr_tick.sv ----
// update pacing timer: one-cycle tick every period cycles
module fdr_tick import fdr_pkg::*; (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // control
  input  wire logic [TMR_W-1:0] period,
  input  wire logic             restart,
  // event
  output logic                  tick
);

  logic [TMR_W-1:0] cnt_q;
  logic [TMR_W-1:0] cnt_d;
  logic             tick_q;
  logic             tick_d;

  always_comb begin
    cnt_d  = cnt_q + TMR_W'(1);
    tick_d = 1'b0;
    if (restart) begin
      cnt_d = '0;
    end else if (cnt_q >= period - TMR_W'(1)) begin
      cnt_d  = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule

// ---- fdr_target.sv ----
// automatic temperature loop: target duty from remote temperature and slope
module fdr_target import fdr_pkg::*; (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // loop settings and measurement
  input  wire logic [7:0] remote_temp,
  input  wire logic [7:0] low_temp,
  input  wire logic [7:0] low_duty,
  input  wire logic [2:0] remote_slope_field,
  // result
  output logic [7:0]      target_duty
);

  logic [7:0]  target_q;
  logic [7:0]  target_d;
  logic [7:0]  rise;
  logic [5:0]  slope;
  logic [14:0] raw;

  always_comb begin
    // codes above the last defined one fall back to the gentlest slope
    slope = SLOPE_BASE >> ((remote_slope_field > SLOPE_MAX_CODE) ? SLOPE_MAX_CODE
                                                                 : remote_slope_field);
    rise  = (remote_temp > low_temp) ? (remote_temp - low_temp) : 8'h00;
    raw      = 15'(low_duty) + 15'(rise) * 15'(slope);
    target_d = (raw > 15'(DUTY_MAX)) ? DUTY_MAX : raw[7:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_q <= 8'h00;
    end else begin
      target_q <= target_d;
    end
  end

  assign target_duty = target_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_slope_rise: assert property (
    ($past(remote_temp) > low_temp) && (remote_temp == $past(remote_temp) + 8'h01)
    && $stable(low_temp) && $stable(low_duty) && $stable(remote_slope_field)
    && (remote_slope_field <= SLOPE_MAX_CODE) && ($past(target_d) <= DUTY_MAX - 8'h20)
    |=> target_q == $past(target_q) + 8'(SLOPE_BASE >> remote_slope_field))
    else $error("target duty did not rise by one slope step");

endmodule

// ---- fdr_fan_model.sv ----
// behavioural cooling fan: tach count follows the pwm duty after a short lag
module fdr_fan_model #(
  parameter int unsigned LAG = 3
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // pwm duty in, tach count out
  input  wire logic [7:0]  duty,
  output logic      [15:0] tach
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] hist_q [LAG];

  // rotor inertia: the count lags the duty, so a loop cannot see its own step at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < LAG; i++) hist_q[i] <= 8'h00;
    end else begin
      hist_q[0] <= duty;
      for (int i = 1; i < LAG; i++) hist_q[i] <= hist_q[i-1];
    end
  end

  // larger count means a slower fan; never reaches zero even at full duty
  assign tach = 16'h0900 - {5'h00, hist_q[LAG-1], 3'h0};
endmodule

// ---- fan_duty_ramp_control_test.sv ----
// self-checking bench for the fan duty ramp block, fan model on the tach side
module fan_duty_ramp_control_test import fdr_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;

  localparam int BASE = 8;
  localparam int FAST = 16;
  localparam int SLOW = 32;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  remote_temp, low_temp, low_duty, duty;
  logic [2:0]  slope;
  logic [15:0] tach, tach_tgt;
  int          bad_count, n_tests, cyc;

  fdr_ramp #(.UPDATE_BASE_CYC(BASE), .RPM_FAST_PER(FAST), .RPM_SLOW_PER(SLOW)) dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .remote_temp(remote_temp), .low_temp(low_temp),
    .low_duty(low_duty), .remote_slope_field(slope), .tach_reading(tach),
    .tach_target(tach_tgt), .duty_cycle_value(duty));

  fdr_fan_model fan (.pclk(pclk), .presetn(presetn), .duty(duty), .tach(tach));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // hang guard: the whole sequence needs well under 5000 cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, {idx, 2'b00}, {24'h0, d}, r, e);
  endtask

  task automatic wait_duty(input logic [7:0] v);
    for (int i = 0; i < 20 && duty !== v; i++) begin
      @(posedge pclk);
      #1;
    end
    chk(32'(duty), 32'(v));
  endtask

  task automatic hold(input int n);
    logic [7:0] v;
    v = duty;
    repeat (n) begin
      @(posedge pclk);
      #1;
      chk(32'(duty), 32'(v));
    end
  endtask

  // follow duty to tgt: each move is min(step, gap) and moves are per cycles apart
  task automatic rwatch(input logic [7:0] tgt, input logic [7:0] st, input int per,
                        input int n);
    logic [7:0] prev, gap, exp;
    int         cnt, last;
    prev = duty;
    cnt = 0;
    last = -1;
    for (int t = 0; t < 4000 && prev !== tgt; t++) begin
      @(posedge pclk);
      #1;
      if (duty !== prev) begin
        gap = (tgt > prev) ? tgt - prev : prev - tgt;
        exp = (gap < st) ? gap : st;
        exp = (tgt > prev) ? prev + exp : prev - exp;
        chk(32'(duty), 32'(exp));
        // the first move depends on where the timer stood
        if (last >= 0) chk(32'(t - last), 32'(per));
        last = t;
        cnt++;
        prev = duty;
      end
    end
    chk(32'(cnt), 32'(n));
  endtask

  initial begin
    logic [31:0] r;
    logic        e;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    remote_temp = 8'h2A;
    low_temp = 8'h28;
    low_duty = 8'h20;
    slope = 3'h2;
    tach_tgt = 16'h0680;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, {IDX_RAMP_CFG, 2'b00}, 32'h0, r, e);
    chk(r, 32'h52);
    chk(32'(duty), 32'h0);
    apb(1'b0, 12'h004, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    apb(1'b1, {IDX_RAMP_CFG, 2'b01}, 32'hFF, r, e);
    chk(32'(e), 32'h1);
    apb(1'b0, {IDX_RAMP_CFG, 2'b00}, 32'h0, r, e);
    chk(r, 32'h52);
    // manual duty mode: ramp settings have no say
    wr(IDX_RAMP_CFG, 8'hDF);
    wr(IDX_SW_DUTY, 8'h40);
    wait_duty(8'h40);
    hold(40);
    // auto, ramp off with the largest step: target loads at once for every slope
    wr(IDX_RAMP_CFG, 8'h60);
    wr(IDX_CTRL, {6'h00, MODE_AUTO});
    for (int c = 0; c < 8; c++) begin
      slope <= 3'(c);
      wait_duty((c > 4) ? 8'h24 : 8'h20 + (8'h40 >> c));
    end
    apb(1'b0, {IDX_STATUS, 2'b00}, 32'h0, r, e);
    chk(r, 32'h0001_2424);
    // widest threshold: a gap of four is held, six is taken
    wr(IDX_RAMP_CFG, 8'h03);
    // code 4 gives the same slope as the fallback, so the one-degree rise is checked too
    slope <= 3'h4;
    remote_temp <= 8'h2C;
    hold(30);
    remote_temp <= 8'h2D;
    wait_duty(8'h2A);
    // ramp up by 4 at rate 7, last move is the remainder of 2
    wr(IDX_RAMP_CFG, 8'hDC);
    slope <= 3'h0;
    rwatch(8'hC0, 8'h04, BASE, 38);
    // ramp down by 8 at rate 6
    wr(IDX_RAMP_CFG, 8'hF8);
    remote_temp <= 8'h28;
    rwatch(8'h20, 8'h08, 2 * BASE, 20);
    // speed mode, ramp bit clear and slowest rate: still steps of 2 on the fast tach pace
    wr(IDX_RAMP_CFG, 8'h20);
    wr(IDX_CTRL, 8'h06);
    rwatch(8'h50, 8'h02, FAST, 24);
    hold(3 * FAST);
    // slow tach pace, step 1: stops once within ten counts
    wr(IDX_RAMP_CFG, 8'h00);
    wr(IDX_CTRL, 8'h03);
    tach_tgt <= 16'h06C0;
    rwatch(8'h49, 8'h01, SLOW, 7);
    hold(3 * SLOW);
    // unreachable speed: duty saturates at full scale
    wr(IDX_RAMP_CFG, 8'h60);
    tach_tgt <= 16'h0000;
    rwatch(8'hFF, 8'h08, SLOW, 23);
    hold(3 * SLOW);
    apb(1'b0, {IDX_STATUS, 2'b00}, 32'h0, r, e);
    chk({22'h0, r[17:16], r[7:0]}, 32'h3FF);
    wr(IDX_CTRL, {6'h00, MODE_MANUAL});
    wait_duty(8'h40);
    end_sim();
  end
endmodule
